// >>> scrs_defs.svh
`ifndef SCRS_DEFS_SVH
`define SCRS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SCRS_OFS_GEN_CFG   8'h03
`define SCRS_OFS_MODE_SEL  8'h04
`define SCRS_OFS_I2C_CTL   8'h05
`define SCRS_OFS_DES_ADDR  8'h06
`define SCRS_OFS_CRC_LO    8'h0a
`define SCRS_OFS_CRC_HI    8'h0b

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define SCRS_RST_GEN_CFG   8'h92
`define SCRS_MSK_GEN_CFG   8'hba
`define SCRS_RST_MODE_SEL  8'h80
`define SCRS_MSK_MODE_SEL  8'hb0
`define SCRS_RST_I2C_CTL   8'h00
`define SCRS_MSK_I2C_CTL   8'h1f
`define SCRS_RST_DES_ADDR  7'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCRS_BIT_PCLK_AUTO   1
`define SCRS_BIT_FAILSAFE    7
`define SCRS_BIT_CRC_CLR     5
`define SCRS_BIT_GATE        4
`define SCRS_FLD_SDA_DLY_HI  4
`define SCRS_FLD_SDA_DLY_LO  3
`define SCRS_BIT_LWR_BLOCK   2
`define SCRS_BIT_WD_SPEEDUP  1
`define SCRS_BIT_WD_DISABLE  0
`define SCRS_BIT_FREEZE      0

// ----------------------------------------
// timing
// ----------------------------------------
`define SCRS_CLK_HZ        40000000
`define SCRS_CLK_PS        25000
`define SCRS_NS2CYC_UP(ns) (((ns) * 1000 + `SCRS_CLK_PS - 1) / `SCRS_CLK_PS)
`define SCRS_SDA_DLY_NS    240
`define SCRS_SDA_STEP_NS   40
`define SCRS_WD_LONG_S     1
`define SCRS_WD_SHORT_US   50
`define SCRS_WD_SHORT_CYC  ((`SCRS_WD_SHORT_US * `SCRS_CLK_HZ) / 1000000)
`define SCRS_CLR_HALF_NS   5000
`define SCRS_CLR_HALF_CYC  `SCRS_NS2CYC_UP(`SCRS_CLR_HALF_NS)
`define SCRS_CLR_PULSES    9

`endif

// >>> scrs_pkg.sv
package scrs_pkg;

	// one register access from the serial control engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic       remote;
		logic [7:0] addr;
		logic [7:0] wdata;
	} scrs_req_s;

	// per-port remote deserializer address state
	typedef struct packed {
		logic [6:0] addr;
		logic       freeze;
	} scrs_port_s;

	typedef enum logic [2:0] {
		SCRS_WD_RUN    = 3'b001,
		SCRS_WD_CLR_LO = 3'b010,
		SCRS_WD_CLR_HI = 3'b100
	} scrs_wd_e;

endpackage

// >>> scrs_sync.sv
`timescale 1ns/100ps

module scrs_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// a bit moves only once stages two and three agree
	assign next_q = (s2 & s3) | (q & (s2 | s3));

	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			q  <= RST;
		end else if (ce) begin
			s1 <= d;
			s2 <= s1;
			s3 <= s2;
			q  <= next_q;
		end
	end

endmodule // scrs_sync

// >>> scrs_crc_count.sv
`timescale 1ns/100ps

module scrs_crc_count (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        clr,
	input  wire logic        inc,
	output logic      [15:0] count
);

	logic        at_max;
	logic [15:0] next_count;

	// saturate rather than wrap, a wrapped count would hide errors
	assign at_max     = &count;
	assign next_count = clr ? 16'h0000 :
		(inc && !at_max) ? count + 16'h0001 : count;

	always_ff @(posedge clk) begin
		if (rst) begin
			count <= 16'h0000;
		end else if (ce) begin
			count <= next_count;
		end
	end

endmodule // scrs_crc_count

// >>> scrs_ctrl_regs.sv
`timescale 1ns/100ps
`include "scrs_defs.svh"


module scrs_ctrl_regs #(
	parameter int WD_LONG_CYC = `SCRS_WD_LONG_S * `SCRS_CLK_HZ
) (
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	input  wire logic                   ce,
	input  wire logic                   link_clk,
	input  wire logic                   link_rst,
	input  wire scrs_pkg::scrs_req_s    reg_req,
	output logic      [7:0]             rd_data,
	output logic                        wr_reject,
	input  wire logic                   second_port_select,
	input  wire logic                   pclk_present,
	output logic                        osc_select,
	output logic                        failsafe_low,
	input  wire logic                   data_enable_in,
	input  wire logic [23:0]            rgb_in,
	output logic      [23:0]            rgb_out,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_oe_n,
	input  wire logic                   scl_in,
	output logic                        scl_out,
	output logic                        scl_oe_n,
	input  wire logic                   sda_drive_low_req,
	output logic                        bus_free,
	input  wire logic [1:0]             rx_lock,
	input  wire logic [1:0][6:0]        rx_des_addr,
	input  wire logic [1:0]             crc_err_pulse,
	output scrs_pkg::scrs_port_s [1:0]  des_port,
	output logic      [1:0]             des_access_en
);

	// ----------------------------------------
	// register storage and decode
	// ----------------------------------------
	logic [7:0]  gen_cfg;
	logic [7:0]  mode_select;
	logic [7:0]  i2c_control;
	logic        local_wr_block;
	logic        wr_ok;
	logic        sel_gen;
	logic        sel_mode;
	logic        sel_i2c;
	logic        sel_des;
	logic        sel_crc_lo;
	logic        sel_crc_hi;
	logic        psel;
	logic [7:0]  wdata;
	logic [7:0]  next_rd;
	logic [15:0] crc_count [2];
	logic [15:0] crc_sel;

	assign psel           = second_port_select;
	assign wdata          = reg_req.wdata;
	assign local_wr_block = i2c_control[`SCRS_BIT_LWR_BLOCK];
	// only remote writes to local registers are gated; pass-through traffic to
	// targets never comes through this port
	assign wr_reject = reg_req.wr && reg_req.remote && local_wr_block;
	assign wr_ok     = ce && reg_req.wr && !wr_reject;

	assign sel_gen    = reg_req.addr == `SCRS_OFS_GEN_CFG;
	assign sel_mode   = reg_req.addr == `SCRS_OFS_MODE_SEL;
	assign sel_i2c    = reg_req.addr == `SCRS_OFS_I2C_CTL;
	assign sel_des    = reg_req.addr == `SCRS_OFS_DES_ADDR;
	assign sel_crc_lo = reg_req.addr == `SCRS_OFS_CRC_LO;
	assign sel_crc_hi = reg_req.addr == `SCRS_OFS_CRC_HI;
	assign crc_sel    = crc_count[psel];

	// unmapped offsets and reserved bits read back as zero
	assign next_rd =
		sel_gen    ? gen_cfg :
		sel_mode   ? mode_select :
		sel_i2c    ? i2c_control :
		sel_des    ? {des_port[psel].addr, des_port[psel].freeze} :
		sel_crc_lo ? crc_sel[7:0] :
		sel_crc_hi ? crc_sel[15:8] :
		8'h00;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			gen_cfg     <= `SCRS_RST_GEN_CFG;
			mode_select <= `SCRS_RST_MODE_SEL;
			i2c_control <= `SCRS_RST_I2C_CTL;
			rd_data     <= 8'h00;
		end else if (ce) begin
			if (reg_req.rd) begin
				rd_data <= next_rd;
			end
			if (wr_ok && sel_gen) begin
				gen_cfg <= wdata & `SCRS_MSK_GEN_CFG;
			end
			if (wr_ok && sel_mode) begin
				mode_select <= wdata & `SCRS_MSK_MODE_SEL;
			end
			if (wr_ok && sel_i2c) begin
				i2c_control <= wdata & `SCRS_MSK_I2C_CTL;
			end
		end
	end

	// ----------------------------------------
	// link domain: lock capture and crc events
	// ----------------------------------------
	logic [1:0]      link_lock_q;
	logic [1:0]      link_crc_tgl;
	logic [1:0][6:0] link_addr_hold;

	// the address is captured on the same edge the lock flag rises, so
	// it is stable long before the core sees the synchronised lock
	always_ff @(posedge link_clk) begin
		if (link_rst) begin
			link_lock_q    <= 2'b00;
			link_crc_tgl   <= 2'b00;
			link_addr_hold <= '0;
		end else begin
			link_lock_q  <= rx_lock;
			link_crc_tgl <= link_crc_tgl ^ crc_err_pulse;
			for (int i = 0; i < 2; i++) begin
				if (rx_lock[i] && !link_lock_q[i]) begin
					link_addr_hold[i] <= rx_des_addr[i];
				end
			end
		end
	end

	// ----------------------------------------
	// crossings into the core domain
	// ----------------------------------------
	logic [1:0] lock_s;
	logic [1:0] lock_d;
	logic [1:0] tgl_s;
	logic [1:0] tgl_d;
	logic       pclk_s;
	logic       scl_s;
	logic       sda_s;

	scrs_sync #(.W(4), .RST(4'h0)) u_link_sync (
		.clk (core_clk),
		.rst (rst),
		.ce  (ce),
		.d   ({link_lock_q, link_crc_tgl}),
		.q   ({lock_s, tgl_s})
	);

	scrs_sync #(.W(3), .RST(3'h6)) u_pin_sync (
		.clk (core_clk),
		.rst (rst),
		.ce  (ce),
		.d   ({scl_in, sda_in, pclk_present}),
		.q   ({scl_s, sda_s, pclk_s})
	);

	// ----------------------------------------
	// per-port address and crc counters
	// ----------------------------------------
	for (genvar p = 0; p < 2; p++) begin : g_port
		logic lock_rise;
		logic des_wr;

		assign lock_rise = lock_s[p] && !lock_d[p];
		assign des_wr    = wr_ok && sel_des && (psel == p);
		assign des_access_en[p] = des_port[p].addr != 7'h00;

		// a load on the same cycle as a write wins, unless frozen
		always_ff @(posedge core_clk) begin
			if (rst) begin
				des_port[p].addr   <= `SCRS_RST_DES_ADDR;
				des_port[p].freeze <= 1'b0;
				lock_d[p]          <= 1'b0;
				tgl_d[p]           <= 1'b0;
			end else if (ce) begin
				lock_d[p] <= lock_s[p];
				tgl_d[p]  <= tgl_s[p];
				if (des_wr) begin
					des_port[p].addr   <= wdata[7:1];
					des_port[p].freeze <= wdata[`SCRS_BIT_FREEZE];
				end
				if (lock_rise && !des_port[p].freeze) begin
					des_port[p].addr <= link_addr_hold[p];
				end
			end
		end

		scrs_crc_count u_crc (
			.clk   (core_clk),
			.rst   (rst),
			.ce    (ce),
			.clr   (mode_select[`SCRS_BIT_CRC_CLR]),
			.inc   (tgl_s[p] ^ tgl_d[p]),
			.count (crc_count[p])
		);
	end

	// ----------------------------------------
	// pixel clock, failsafe and rgb gating
	// ----------------------------------------
	logic        gate_on;
	logic [23:0] next_rgb;

	assign gate_on  = mode_select[`SCRS_BIT_GATE];
	assign next_rgb = (gate_on && !data_enable_in) ? 24'h000000 : rgb_in;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			osc_select   <= 1'b0;
			failsafe_low <= 1'b1;
			rgb_out      <= 24'h000000;
		end else if (ce) begin
			osc_select   <= gen_cfg[`SCRS_BIT_PCLK_AUTO] && !pclk_s;
			failsafe_low <= mode_select[`SCRS_BIT_FAILSAFE];
			rgb_out      <= next_rgb;
		end
	end

	// ----------------------------------------
	// sda output delay
	// ----------------------------------------
	logic [4:0] sda_dly_cyc;
	logic [4:0] sda_cnt;
	logic [1:0] dly_sel;
	logic       scl_prev;
	logic       scl_fall;

	// delay is measured from the synchronised edge, so the pin sees
	// about five extra cycles (four through the sync, one to load the count)
	assign dly_sel     = i2c_control[`SCRS_FLD_SDA_DLY_HI:`SCRS_FLD_SDA_DLY_LO];
	assign sda_dly_cyc = 5'(`SCRS_NS2CYC_UP(`SCRS_SDA_DLY_NS
		+ `SCRS_SDA_STEP_NS * int'(dly_sel)));
	assign scl_fall    = scl_prev && !scl_s;
	assign sda_out     = 1'b0;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scl_prev <= 1'b1;
			sda_cnt  <= 5'h00;
			sda_oe_n <= 1'b1;
		end else if (ce) begin
			scl_prev <= scl_s;
			if (scl_fall) begin
				sda_cnt <= sda_dly_cyc;
			end else if (sda_cnt != 5'h00) begin
				sda_cnt <= sda_cnt - 5'h01;
			end
			if (sda_cnt == 5'h01) begin
				sda_oe_n <= !sda_drive_low_req;
			end
		end
	end

	// ----------------------------------------
	// bus watchdog and bus clear
	// ----------------------------------------
	scrs_pkg::scrs_wd_e wd_state;
	scrs_pkg::scrs_wd_e next_wd_state;
	logic [25:0] wd_cnt;
	logic [25:0] wd_limit;
	logic [7:0]  half_cnt;
	logic [3:0]  pulse_cnt;
	logic        wd_on;
	logic        sda_prev;
	logic        activity;
	logic        timeout;
	logic        half_done;

	assign wd_on    = !i2c_control[`SCRS_BIT_WD_DISABLE];
	assign wd_limit = i2c_control[`SCRS_BIT_WD_SPEEDUP]
		? 26'(`SCRS_WD_SHORT_CYC) : 26'(WD_LONG_CYC);
	assign activity  = scl_fall || (scl_prev != scl_s) || (sda_prev != sda_s);
	assign timeout   = wd_on && (wd_cnt >= wd_limit - 26'h1);
	assign half_done = half_cnt == 8'(`SCRS_CLR_HALF_CYC - 1);
	assign scl_out   = 1'b0;

	always_comb begin
		next_wd_state = wd_state;
		case (wd_state)
			scrs_pkg::SCRS_WD_RUN: begin
				if (timeout && !activity && !sda_s) begin
					next_wd_state = scrs_pkg::SCRS_WD_CLR_LO;
				end
			end
			scrs_pkg::SCRS_WD_CLR_LO: begin
				if (half_done) begin
					next_wd_state = scrs_pkg::SCRS_WD_CLR_HI;
				end
			end
			scrs_pkg::SCRS_WD_CLR_HI: begin
				if (half_done && pulse_cnt == 4'(`SCRS_CLR_PULSES - 1)) begin
					next_wd_state = scrs_pkg::SCRS_WD_RUN;
				end else if (half_done) begin
					next_wd_state = scrs_pkg::SCRS_WD_CLR_LO;
				end
			end
			default: begin
				next_wd_state = scrs_pkg::SCRS_WD_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wd_state  <= scrs_pkg::SCRS_WD_RUN;
			wd_cnt    <= 26'h0000000;
			half_cnt  <= 8'h00;
			pulse_cnt <= 4'h0;
			sda_prev  <= 1'b1;
			bus_free  <= 1'b0;
			scl_oe_n  <= 1'b1;
		end else if (ce) begin
			wd_state <= wd_on ? next_wd_state : scrs_pkg::SCRS_WD_RUN;
			sda_prev <= sda_s;
			scl_oe_n <= !(wd_on && next_wd_state == scrs_pkg::SCRS_WD_CLR_LO);
			if (!wd_on || activity || wd_state != scrs_pkg::SCRS_WD_RUN) begin
				wd_cnt <= 26'h0000000;
			end else if (!timeout) begin
				wd_cnt <= wd_cnt + 26'h1;
			end
			if (!wd_on || activity) begin
				bus_free <= 1'b0;
			end else if (timeout && sda_s) begin
				bus_free <= 1'b1;
			end
			if (wd_state == scrs_pkg::SCRS_WD_RUN || half_done) begin
				half_cnt <= 8'h00;
			end else begin
				half_cnt <= half_cnt + 8'h01;
			end
			if (wd_state == scrs_pkg::SCRS_WD_RUN) begin
				pulse_cnt <= 4'h0;
			end else if (wd_state == scrs_pkg::SCRS_WD_CLR_HI && half_done) begin
				pulse_cnt <= pulse_cnt + 4'h1;
			end
		end
	end

endmodule // scrs_ctrl_regs

// >>> scrs_props.sv
`timescale 1ns/100ps

module scrs_props #(
	parameter int WD_LONG_CYC = 40000000
) (
	input wire logic                       core_clk,
	input wire logic                       rst,
	input wire logic                       ce,
	input wire scrs_pkg::scrs_req_s        reg_req,
	input wire logic                       wr_reject,
	input wire logic                       pclk_present,
	input wire logic                       osc_select,
	input wire logic                       failsafe_low,
	input wire logic                       data_enable_in,
	input wire logic [23:0]                rgb_in,
	input wire logic [23:0]                rgb_out,
	input wire logic                       sda_in,
	input wire logic                       scl_in,
	input wire logic                       scl_oe_n,
	input wire logic                       bus_free,
	input wire scrs_pkg::scrs_port_s [1:0] des_port,
	input wire logic [1:0]                 des_access_en
);
	// sync slack taken off the shorter of the two timeouts
	localparam int QMIN = (WD_LONG_CYC < 2000 ? WD_LONG_CYC : 2000) - 10;
	int low_n, high_n, pulse_n, quiet_n, up_n;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	// ----
	// helper counters
	// ----
	always_ff @(posedge core_clk) low_n <= (rst || scl_oe_n) ? 0 : low_n + 1;
	always_ff @(posedge core_clk)
		high_n <= (rst || !scl_oe_n) ? 0 : high_n + (high_n < 999);
	always_ff @(posedge core_clk)
		pulse_n <= rst ? 0 : !$fell(scl_oe_n) ? pulse_n :
			(high_n > 300 ? 1 : pulse_n + 1);
	always_ff @(posedge core_clk)
		quiet_n <= (rst || !sda_in || !scl_in) ? 0 : quiet_n + 1;
	always_ff @(posedge core_clk) up_n <= rst ? 0 : up_n + (up_n < 15);

	// ----
	// properties
	// ----
	property p_fs;
		reg_req.wr && !reg_req.remote && ce && reg_req.addr == 8'h04
			|-> ##2 failsafe_low == $past(reg_req.wdata[7], 2);
	endproperty
	a_fs: assert property (p_fs) else $error("failsafe level wrong");
	property p_blk;
		wr_reject && reg_req.addr == 8'h04
			|-> ##2 $stable(failsafe_low);
	endproperty
	a_blk: assert property (p_blk) else $error("blocked write landed");
	property p_acc;
		des_access_en == {|des_port[1].addr, |des_port[0].addr};
	endproperty
	a_acc: assert property (p_acc) else $error("access enable wrong");
	property p_rgb;
		!$past(rst) && $past(ce) && $past(data_enable_in)
			|-> rgb_out == $past(rgb_in);
	endproperty
	a_rgb: assert property (p_rgb) else $error("rgb lost with de high");
	property p_osc;
		(pclk_present && up_n == 15) [*8] |-> !osc_select;
	endproperty
	a_osc: assert property (p_osc) else $error("osc with pclk present");
	property p_len;
		$rose(scl_oe_n) && !$past(rst) |-> low_n == 200;
	endproperty
	a_len: assert property (p_len) else $error("scl pulse length");
	property p_cnt;
		$fell(scl_oe_n) && high_n <= 300 |-> pulse_n < 9;
	endproperty
	a_cnt: assert property (p_cnt) else $error("too many scl pulses");
	property p_free;
		$rose(bus_free) && !$past(rst) |-> quiet_n >= QMIN;
	endproperty
	a_free: assert property (p_free) else $error("bus free too early");
	property p_frz;
		$past(des_port[0].freeze) && !$past(reg_req.wr) && !$past(rst)
			|-> $stable(des_port[0].addr);
	endproperty
	a_frz: assert property (p_frz) else $error("frozen address moved");
endmodule // scrs_props

bind scrs_ctrl_regs scrs_props #(.WD_LONG_CYC(WD_LONG_CYC)) u_props (.*);

// >>> scrs_far_model.sv
`timescale 1ns/100ps

module scrs_far_model (
	input  wire logic            link_clk,
	output logic      [1:0]      rx_lock,
	output logic      [1:0][6:0] rx_des_addr,
	output logic      [1:0]      crc_err_pulse
);
	initial begin
		rx_lock = '0;
		rx_des_addr = '0;
		crc_err_pulse = '0;
	end

	// unlocked lanes carry no address, so never hold the last one
	always @(posedge link_clk) begin
		if (!rx_lock[0])
			rx_des_addr[0] <= ~rx_des_addr[0];
		if (!rx_lock[1])
			rx_des_addr[1] <= ~rx_des_addr[1];
	end

	task automatic lock(int p, logic [6:0] a);
		@(posedge link_clk);
		#1;
		rx_des_addr[p] = a;
		rx_lock[p] = 1'b1;
	endtask

	task automatic unlock(int p);
		@(posedge link_clk);
		#1;
		rx_lock[p] = 1'b0;
	endtask

	// spaced so each error lands as its own core-side event
	task automatic errs(int p, int n);
		repeat (n) begin
			@(posedge link_clk);
			#1;
			crc_err_pulse[p] = 1'b1;
			@(posedge link_clk);
			#1;
			crc_err_pulse[p] = 1'b0;
			repeat (16) @(posedge link_clk);
		end
	endtask
endmodule // scrs_far_model

// >>> tb_top.sv
`timescale 1ns/100ps

module tb_top;
	logic core_clk, link_clk, rst, link_rst, ce, second_port_select;
	logic pclk_present, data_enable_in, sda_h, scl_h, sda_drive_low_req;
	logic [23:0] rgb_in, rgb_out;
	scrs_pkg::scrs_req_s reg_req;
	scrs_pkg::scrs_port_s [1:0] des_port;
	logic [7:0] rd_data;
	logic wr_reject, osc_select, failsafe_low, sda_out, scl_out;
	logic sda_oe_n, scl_oe_n, bus_free, sda_in, scl_in;
	logic [1:0] rx_lock, crc_err_pulse, des_access_en;
	logic [1:0][6:0] rx_des_addr;
	int fail_count, n_compared;

	// open-drain lines: either party may pull low
	assign sda_in = sda_h & sda_oe_n;
	assign scl_in = scl_h & scl_oe_n;

	scrs_ctrl_regs #(.WD_LONG_CYC(3000)) i_dut (.*);
	scrs_far_model i_far (.*);

	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// ----
	// helpers
	// ----
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic conclude;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic hang(int i, int lim);
		if (i >= lim) begin
			chk("wait_bound", lim - 1, i);
			conclude();
		end
	endtask
	task automatic go(scrs_pkg::scrs_req_s r);
		reg_req = r;
		@(posedge core_clk);
		reg_req <= '0;
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d, logic rm);
		go('{1'b1, 1'b0, rm, a, d});
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		go('{1'b0, 1'b1, 1'b0, a, 8'h00});
		chk($sformatf("reg_%h", a), e, rd_data);
	endtask

	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd(8'h03, 8'h92);
		rd(8'h04, 8'h80);
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		chk("failsafe", 1, failsafe_low);
	endtask
	task automatic t_regs;
		wr(8'h04, 8'h7f, 0);
		rd(8'h04, 8'h30);
		chk("failsafe", 0, failsafe_low);
		// a write while the clock enable is low must not land
		ce = 0;
		wr(8'h04, 8'h80, 0);
		ce = 1;
		rd(8'h04, 8'h30);
		wr(8'h05, 8'hff, 0);
		rd(8'h05, 8'h1f);
		wr(8'h0b, 8'h55, 0);
		rd(8'h0b, 8'h00);
		rd(8'h00, 8'h00);
		wr(8'h04, 8'h80, 0);
		wr(8'h05, 8'h05, 0);
	endtask
	task automatic t_block;
		reg_req = '{1'b1, 1'b0, 1'b1, 8'h04, 8'h10};
		#1;
		chk("wr_reject", 1, wr_reject);
		@(posedge core_clk);
		reg_req <= '0;
		#1;
		rd(8'h04, 8'h80);
		wr(8'h05, 8'h00, 0);
		wr(8'h04, 8'h90, 1);
		rd(8'h04, 8'h90);
	endtask
	task automatic t_gate;
		rgb_in = 24'h5a5a5a;
		cyc(2);
		chk("rgb_gated", 24'h000000, rgb_out);
		data_enable_in = 1;
		cyc(2);
		chk("rgb_de", 24'h5a5a5a, rgb_out);
		wr(8'h04, 8'h80, 0);
		data_enable_in = 0;
		rgb_in = 24'hc3c3c3;
		cyc(2);
		chk("rgb_pass", 24'hc3c3c3, rgb_out);
	endtask
	task automatic t_osc;
		int i;
		pclk_present = 0;
		for (i = 0; i < 40 && osc_select !== 1; i++) cyc(1);
		hang(i, 40);
		wr(8'h03, 8'h90, 0);
		cyc(10);
		chk("osc_off", 0, osc_select);
		wr(8'h03, 8'h92, 0);
		pclk_present = 1;
		cyc(10);
		chk("osc_pclk", 0, osc_select);
	endtask
	task automatic t_des;
		int i;
		i_far.lock(0, 7'h2a);
		for (i = 0; i < 40 && des_port[0].addr !== 7'h2a; i++) cyc(1);
		hang(i, 40);
		chk("access", 2'b01, des_access_en);
		rd(8'h06, 8'h54);
		wr(8'h06, 8'h23, 0);
		i_far.unlock(0);
		cyc(10);
		i_far.lock(0, 7'h33);
		cyc(40);
		rd(8'h06, 8'h23);
		second_port_select = 1;
		wr(8'h06, 8'h46, 0);
		chk("port1", 7'h23, des_port[1].addr);
		rd(8'h06, 8'h46);
		second_port_select = 0;
		rd(8'h06, 8'h23);
		wr(8'h06, 8'h00, 0);
		chk("blocked", 2'b10, des_access_en);
	endtask
	task automatic t_crc;
		i_far.errs(0, 3);
		cyc(10);
		rd(8'h0a, 8'h03);
		rd(8'h0b, 8'h00);
		wr(8'h04, 8'ha0, 0);
		i_far.errs(0, 2);
		cyc(10);
		rd(8'h0a, 8'h00);
		rd(8'h04, 8'ha0);
		wr(8'h04, 8'h80, 0);
		rd(8'h0a, 8'h00);
		i_far.errs(1, 2);
		cyc(10);
		second_port_select = 1;
		rd(8'h0a, 8'h02);
		second_port_select = 0;
		rd(8'h0a, 8'h00);
	endtask
	task automatic t_delay;
		int f, i, off;
		int n[4] = '{10, 12, 13, 15};
		// four edges through the pin sync, one to load the delay count
		off = 5;
		for (f = 0; f < 4; f++) begin
			wr(8'h05, {3'h0, f[1:0], 3'h1}, 0);
			sda_drive_low_req = 1;
			cyc(20);
			scl_h = 0;
			for (i = 0; i < 40 && sda_oe_n !== 0; i++) cyc(1);
			hang(i, 40);
			chk("sda_delay", n[f] + off, i);
			chk("sda_out", 0, sda_out);
			sda_drive_low_req = 0;
			cyc(20);
			scl_h = 1;
			cyc(20);
			scl_h = 0;
			cyc(30);
			scl_h = 1;
		end
	endtask
	task automatic t_wd;
		int i, p;
		logic last;
		wr(8'h05, 8'h02, 0);
		sda_h = 0;
		for (i = 0; i < 2100 && scl_oe_n !== 0; i++) cyc(1);
		chk("wd_short", 1, i > 1990 && i < 2020);
		p = 0;
		last = 1;
		for (i = 0; i < 3800; i++) begin
			p += (scl_oe_n === 0 && last === 1);
			last = scl_oe_n;
			cyc(1);
		end
		chk("clr_pulses", 9, p);
		chk("scl_out", 0, scl_out);
		wr(8'h05, 8'h01, 0);
		for (i = 0; i < 3100 && scl_oe_n === 1; i++) cyc(1);
		chk("wd_off", 3100, i);
		sda_h = 1;
		cyc(5);
		chk("free_off", 0, bus_free);
		wr(8'h05, 8'h00, 0);
		scl_h = 0;
		cyc(2);
		scl_h = 1;
		for (i = 0; i < 3200 && bus_free !== 1; i++) cyc(1);
		chk("wd_long", 1, i > 2980 && i < 3100);
	endtask

	initial begin
		fail_count = 0;
		n_compared = 0;
		rst = 1;
		link_rst = 1;
		ce = 1;
		reg_req = '0;
		second_port_select = 0;
		pclk_present = 1;
		data_enable_in = 0;
		rgb_in = '0;
		sda_h = 1;
		scl_h = 1;
		sda_drive_low_req = 0;
		repeat (12) @(posedge core_clk);
		#1;
		rst = 0;
		link_rst = 0;
		t_reset();
		t_regs();
		t_block();
		t_gate();
		t_osc();
		t_des();
		t_crc();
		t_delay();
		t_wd();
		conclude();
	end
endmodule // tb_top
